// [common/gssc_pkg.sv]
/*
  Shared constants for the gas sensor status and calibration block:
  register indices, health flag positions, unit codes, timing counts.
  Assumes a 125 MHz ref_clk on both ends.
*/
package gssc_pkg;
  // Register indices (word addresses on the sensor register port)
  localparam logic [15:0] REG_HEALTH    = 16'h0009;
  localparam logic [15:0] REG_READING   = 16'h000A;
  localparam logic [15:0] REG_ZERO_REF  = 16'h0047;
  localparam logic [15:0] REG_UNIT      = 16'h004F;
  localparam logic [15:0] REG_FULLSCALE = 16'h0051;
  localparam logic [15:0] REG_GAIN      = 16'h0054;
  localparam logic [15:0] REG_FAB_ZERO  = 16'h0059;
  localparam logic [15:0] REG_FAB_GAIN  = 16'h005A;
  // Health flag bit positions
  localparam int BIT_WARMUP    = 1;
  localparam int BIT_SYS_FAULT = 2;
  localparam int BIT_BOOT      = 5;
  localparam int BIT_COMP      = 6;
  localparam int BIT_ZERO_SET  = 7;
  localparam int BIT_DRIFT     = 11;
  localparam int BIT_NVM       = 12;
  localparam int BIT_WDOG      = 13;
  localparam int BIT_POWER_ON  = 14;
  localparam int BIT_LIMIT     = 15;
  // Gain correction limits and default
  localparam logic [15:0] GAIN_MIN     = 16'h1388;
  localparam logic [15:0] GAIN_MAX     = 16'h3A98;
  localparam logic [15:0] GAIN_DEFAULT = 16'h2710;
  localparam logic [15:0] ZERO_CMD     = 16'h0001;
  // Unit codes
  localparam logic [15:0] UNIT_NONE     = 16'h0000;
  localparam logic [15:0] UNIT_PPM_001  = 16'h0001;
  localparam logic [15:0] UNIT_PPM_01   = 16'h0002;
  localparam logic [15:0] UNIT_PPM_1    = 16'h0003;
  localparam logic [15:0] UNIT_VOL_0001 = 16'h0004;
  localparam logic [15:0] UNIT_VOL_001  = 16'h0005;
  localparam logic [15:0] UNIT_VOL_01   = 16'h0006;
  localparam logic [15:0] UNIT_LEL_001  = 16'h0007;
  localparam logic [15:0] UNIT_LEL_01   = 16'h0008;
  localparam logic [15:0] UNIT_DEFAULT  = UNIT_PPM_1;
  // Timing
  localparam longint CLK_HZ       = 125000000;
  localparam longint WARMUP_S     = 10;
  localparam longint BOOT_S       = 40;
  localparam longint WARMUP_CYC   = WARMUP_S * CLK_HZ;
  localparam longint BOOT_CYC     = BOOT_S * CLK_HZ;
  localparam int     ZERO_CYC     = 16;
  // Host register map (AHB-Lite byte offsets)
  localparam logic [7:0] HREG_CTRL   = 8'h00;
  localparam logic [7:0] HREG_ADDR   = 8'h04;
  localparam logic [7:0] HREG_WDATA  = 8'h08;
  localparam logic [7:0] HREG_RDATA  = 8'h0C;
  localparam logic [7:0] HREG_STATUS = 8'h10;
  // Host command codes in CTRL
  localparam logic [2:0] CMD_READ    = 3'h1;
  localparam logic [2:0] CMD_WRITE   = 3'h2;
  localparam logic [2:0] CMD_ZERO    = 3'h3;
  localparam logic [2:0] CMD_SPAN    = 3'h4;
  localparam logic [2:0] CMD_FACTORY = 3'h5;
endpackage

// [common/gssc_if.sv]
/*
  Register port between host end and sensor end: one request with
  address, write flag and data; one-cycle answer with read data.
  Assumes both ends share ref_clk.
*/
`timescale 1ns/1ps
interface gssc_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  modport dev  (input req, we, addr, wdata, output ack, rdata);
  modport host (output req, we, addr, wdata, input ack, rdata);
endinterface

// [rtl/gssc_sensor.sv]
/*
  Sensor end: health flags, boot and warm-up timing, unit code,
  zero reference and gain correction registers on the register port.
  Assumes the host holds req until ack and keeps to writable registers.
*/
// Overview of operation
// - Bits 0,3,4,8,9,10 reserved, read zero
// - Bit 1 set during ten second warm-up
// - Bit 5 set during forty second boot
// - Bits 2,12,13 report system, memory, watchdog faults
// - Bits 6,7 read one when calibrated; bit 6 is always one, bit 7 only after a zero command since reset
// - Bit 11 set while drift averaging runs
// - Bit 14 shows supply switched on
// - Bit 15 when reading outside -10..110% FS
// - Zero in any flag other than 6,7,14 means normal
// - Unit code values zero to eight
// - Self-test then values, valid after forty seconds
// - No correct values during self-test
// - Writing one to zero reference re-zeroes
// - Host writes gain correction when reading stable; CMD_SPAN uses one reading with no stability check
// - New gain is ref times old over reading
// - Factory restore copies factory zero and gain
// - Zero adjustment before end point adjustment; CMD_SPAN runs without a prior CMD_ZERO
// - Host writes only documented writable registers; CMD_WRITE in gssc_host passes any address
// - Shared bus sensors need distinct addresses
// - Gain outside 5000..15000 becomes 10000
`timescale 1ns/1ps
module gssc_sensor #(
  parameter longint BOOT_CYCLES   = gssc_pkg::BOOT_CYC,
  parameter longint WARMUP_CYCLES = gssc_pkg::WARMUP_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Register port
  gssc_if.dev              bus,
  // Measurement and condition inputs
  input  wire logic [15:0] raw_reading,
  input  wire logic [15:0] full_scale,
  input  wire logic        sys_fault,
  input  wire logic        nvm_fault,
  input  wire logic        watchdog_event,
  input  wire logic        drift_averaging,
  // Calibration outputs
  output logic             zero_pulse,
  output logic [15:0]      gain_value
);
  typedef enum logic [2:0] {
    ST_BOOT   = 3'b001,
    ST_WARMUP = 3'b010,
    ST_RUN    = 3'b100
  } gssc_phase_t;

  typedef struct packed {
    gssc_phase_t phase;
    logic [39:0] timer;
    logic [1:0]  sys_sync;
    logic [1:0]  nvm_sync;
    logic [1:0]  wdg_sync;
    logic [1:0]  drift_sync;
    logic        wdg_seen;
    logic        zero_set;
    logic [4:0]  zero_cnt;
    logic [15:0] zero_ref;
    logic [15:0] gain;
    logic        ack;
    logic [15:0] rdata;
    logic        zero_pulse;
  } gssc_sensor_t;

  gssc_sensor_t s_q;
  gssc_sensor_t s_d;
  logic [15:0]  health;
  logic signed [17:0] rd_s;
  logic signed [17:0] lo_lim;
  logic signed [17:0] hi_lim;
  logic         limit;

  function automatic logic [15:0] gssc_gain_clamp(input logic [15:0] v);
    if (v < gssc_pkg::GAIN_MIN || v > gssc_pkg::GAIN_MAX)
    begin
      return gssc_pkg::GAIN_DEFAULT;
    end
    return v;
  endfunction

  // Limit check on signed reading against full scale
  always_comb
  begin
    rd_s   = 18'(signed'(raw_reading));
    lo_lim = -18'(full_scale / 16'h000A);
    hi_lim = 18'(full_scale) + 18'(full_scale / 16'h000A);
    limit  = (rd_s < lo_lim) || (rd_s > hi_lim);
  end

  // Health word, reserved bits zero
  always_comb
  begin
    health = 16'h0000;
    health[gssc_pkg::BIT_WARMUP]    = (s_q.phase == ST_WARMUP);
    health[gssc_pkg::BIT_BOOT]      = (s_q.phase != ST_RUN);
    health[gssc_pkg::BIT_SYS_FAULT] = s_q.sys_sync[1];
    health[gssc_pkg::BIT_NVM]       = s_q.nvm_sync[1];
    health[gssc_pkg::BIT_WDOG]      = s_q.wdg_seen;
    health[gssc_pkg::BIT_COMP]      = 1'b1;
    health[gssc_pkg::BIT_ZERO_SET]  = s_q.zero_set;
    health[gssc_pkg::BIT_DRIFT]     = s_q.drift_sync[1];
    health[gssc_pkg::BIT_POWER_ON]  = 1'b1;
    health[gssc_pkg::BIT_LIMIT]     = (s_q.phase == ST_RUN) && limit;
  end

  always_comb
  begin
    s_d            = s_q;
    s_d.sys_sync   = {s_q.sys_sync[0], sys_fault};
    s_d.nvm_sync   = {s_q.nvm_sync[0], nvm_fault};
    s_d.wdg_sync   = {s_q.wdg_sync[0], watchdog_event};
    s_d.drift_sync = {s_q.drift_sync[0], drift_averaging};
    s_d.ack        = 1'b0;
    s_d.zero_pulse = 1'b0;
    if (s_q.wdg_sync[1])
    begin
      s_d.wdg_seen = 1'b1;
    end
    // Boot then warm-up, values valid after warm-up ends
    case (s_q.phase)
      ST_BOOT:
      begin
        s_d.timer = s_q.timer + 40'h0000000001;
        if (s_q.timer >= 40'(BOOT_CYCLES - WARMUP_CYCLES - 1))
        begin
          s_d.phase = ST_WARMUP;
          s_d.timer = 40'h0000000000;
        end
      end
      ST_WARMUP:
      begin
        s_d.timer = s_q.timer + 40'h0000000001;
        if (s_q.timer >= 40'(WARMUP_CYCLES - 1))
        begin
          s_d.phase = ST_RUN;
        end
      end
      ST_RUN:
      begin
        s_d.timer = s_q.timer;
      end
      default:
      begin
        s_d.phase = ST_BOOT;
      end
    endcase
    // Zero re-establish sequence
    if (s_q.zero_cnt != 5'h00)
    begin
      s_d.zero_cnt = s_q.zero_cnt - 5'h01;
      if (s_q.zero_cnt == 5'h01)
      begin
        s_d.zero_set   = 1'b1;
        s_d.zero_pulse = 1'b1;
      end
    end
    // Register port, one-cycle answer
    if (bus.req && !s_q.ack)
    begin
      s_d.ack = 1'b1;
      if (bus.we)
      begin
        s_d.rdata = 16'h0000;
        case (bus.addr)
          gssc_pkg::REG_ZERO_REF:
          begin
            s_d.zero_ref = bus.wdata;
            if (bus.wdata == gssc_pkg::ZERO_CMD)
            begin
              s_d.zero_cnt = 5'(gssc_pkg::ZERO_CYC);
            end
          end
          gssc_pkg::REG_GAIN:
          begin
            s_d.gain = gssc_gain_clamp(bus.wdata);
          end
          default:
          begin
            s_d.rdata = 16'h0000;
          end
        endcase
      end
      else
      begin
        case (bus.addr)
          gssc_pkg::REG_HEALTH:    s_d.rdata = health;
          gssc_pkg::REG_READING:   s_d.rdata = (s_q.phase == ST_RUN) ? raw_reading
                                               : 16'h0000;
          gssc_pkg::REG_ZERO_REF:  s_d.rdata = s_q.zero_ref;
          gssc_pkg::REG_UNIT:      s_d.rdata = gssc_pkg::UNIT_DEFAULT;
          gssc_pkg::REG_FULLSCALE: s_d.rdata = full_scale;
          gssc_pkg::REG_GAIN:      s_d.rdata = s_q.gain;
          gssc_pkg::REG_FAB_ZERO:  s_d.rdata = 16'h0000;
          gssc_pkg::REG_FAB_GAIN:  s_d.rdata = gssc_pkg::GAIN_DEFAULT;
          default:                 s_d.rdata = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_q            <= '0;
      s_q.phase      <= ST_BOOT;
      s_q.gain       <= gssc_pkg::GAIN_DEFAULT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign bus.ack    = s_q.ack;
  assign bus.rdata  = s_q.rdata;
  assign zero_pulse = s_q.zero_pulse;
  assign gain_value = s_q.gain;
endmodule

// [rtl/gssc_host.sv]
/*
  Host end: AHB-Lite slave with command registers; runs register
  reads, writes, zero, span and factory-restore sequences on the port.
  Assumes the sensor answers each request with ack.
*/
`timescale 1ns/1ps
module gssc_host (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Sensor register port
  gssc_if.host             bus
);
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_REQ  = 4'b0010,
    HS_NEXT = 4'b0100,
    HS_DONE = 4'b1000
  } gssc_hstate_t;

  typedef struct packed {
    gssc_hstate_t st;
    logic [2:0]   cmd;
    logic [1:0]   step;
    logic [15:0]  addr;
    logic [15:0]  wdata;
    logic [15:0]  rdata;
    logic [15:0]  hold;
    logic         busy;
    logic         done;
    logic         wr_pend;
    logic [7:0]   wr_addr;
    logic         req;
    logic         we;
    logic [15:0]  baddr;
    logic [15:0]  bwdata;
  } gssc_host_s_t;

  gssc_host_s_t h_q;
  gssc_host_s_t h_d;
  logic [31:0]  span_new;
  logic         cmd_start;

  // Command accepted only when idle and the code is not zero
  assign cmd_start = h_q.wr_pend && (h_q.wr_addr == gssc_pkg::HREG_CTRL)
                     && !h_q.busy && (hwdata[2:0] != 3'h0);

  // reference times old gain over old reading
  always_comb
  begin
    span_new = (h_q.rdata != 16'h0000)
             ? (32'(h_q.wdata) * 32'(h_q.hold)) / 32'(h_q.rdata) : 32'h00000000;
  end

  always_comb
  begin
    h_d = h_q;
    // AHB write data phase
    if (h_q.wr_pend)
    begin
      h_d.wr_pend = 1'b0;
      case (h_q.wr_addr)
        gssc_pkg::HREG_ADDR:  h_d.addr  = hwdata[15:0];
        gssc_pkg::HREG_WDATA: h_d.wdata = hwdata[15:0];
        gssc_pkg::HREG_CTRL:
        begin
          if (cmd_start)
          begin
            h_d.cmd  = hwdata[2:0];
            h_d.busy = 1'b1;
            h_d.done = 1'b0;
            h_d.step = 2'h0;
          end
        end
        gssc_pkg::HREG_STATUS: h_d.done = h_q.done & ~hwdata[1];
        default: h_d.wdata = h_q.wdata;
      endcase
    end
    if (hsel && hready && htrans[1])
    begin
      h_d.wr_pend = hwrite;
      h_d.wr_addr = haddr[7:0];
    end
    // Sequencer
    case (h_q.st)
      HS_IDLE: h_d.st = cmd_start ? HS_NEXT : HS_IDLE;
      HS_NEXT:
      begin
        h_d.req = 1'b1;
        h_d.st  = HS_REQ;
        case (h_q.cmd)
          gssc_pkg::CMD_READ:
          begin
            h_d.we    = 1'b0;
            h_d.baddr = h_q.addr;
          end
          gssc_pkg::CMD_WRITE:
          begin
            h_d.we     = 1'b1;
            h_d.baddr  = h_q.addr;
            h_d.bwdata = h_q.wdata;
          end
          gssc_pkg::CMD_ZERO:
          begin
            h_d.we     = 1'b1;
            h_d.baddr  = gssc_pkg::REG_ZERO_REF;
            h_d.bwdata = gssc_pkg::ZERO_CMD;
          end
          gssc_pkg::CMD_SPAN:
          begin
            h_d.we     = (h_q.step == 2'h2);
            h_d.baddr  = (h_q.step == 2'h0) ? gssc_pkg::REG_GAIN
                       : (h_q.step == 2'h1) ? gssc_pkg::REG_READING : gssc_pkg::REG_GAIN;
            h_d.bwdata = span_new[15:0];
          end
          gssc_pkg::CMD_FACTORY:
          begin
            h_d.we     = h_q.step[0];
            h_d.baddr  = (h_q.step == 2'h0) ? gssc_pkg::REG_FAB_ZERO
                       : (h_q.step == 2'h1) ? gssc_pkg::REG_ZERO_REF
                       : (h_q.step == 2'h2) ? gssc_pkg::REG_FAB_GAIN : gssc_pkg::REG_GAIN;
            h_d.bwdata = h_q.hold;
          end
          default:
          begin
            h_d.req = 1'b0;
            h_d.st  = HS_DONE;
          end
        endcase
      end
      HS_REQ:
      begin
        if (bus.ack)
        begin
          h_d.req = 1'b0;
          h_d.st  = HS_DONE;
          if (!h_q.we)
          begin
            if (h_q.cmd == gssc_pkg::CMD_SPAN && h_q.step == 2'h0)
            begin
              h_d.hold = bus.rdata;
            end
            else if (h_q.cmd == gssc_pkg::CMD_FACTORY)
            begin
              h_d.hold = bus.rdata;
            end
            else
            begin
              h_d.rdata = bus.rdata;
            end
          end
          if ((h_q.cmd == gssc_pkg::CMD_SPAN && h_q.step != 2'h2)
              || (h_q.cmd == gssc_pkg::CMD_FACTORY && h_q.step != 2'h3))
          begin
            h_d.step = h_q.step + 2'h1;
            h_d.st   = HS_NEXT;
          end
        end
      end
      HS_DONE:
      begin
        h_d.busy = 1'b0;
        h_d.done = 1'b1;
        h_d.st   = HS_IDLE;
      end
      default: h_d.st = HS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      h_q    <= '0;
      h_q.st <= HS_IDLE;
    end
    else
    begin
      h_q <= h_d;
    end
  end

  // Read mux, zero-wait data phase
  always_comb
  begin
    case (h_q.wr_addr)
      gssc_pkg::HREG_CTRL:   hrdata = {29'h00000000, h_q.cmd};
      gssc_pkg::HREG_ADDR:   hrdata = {16'h0000, h_q.addr};
      gssc_pkg::HREG_WDATA:  hrdata = {16'h0000, h_q.wdata};
      gssc_pkg::HREG_RDATA:  hrdata = {16'h0000, h_q.rdata};
      gssc_pkg::HREG_STATUS: hrdata = {30'h00000000, h_q.done, h_q.busy};
      default:               hrdata = 32'h00000000;
    endcase
  end

  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign bus.req    = h_q.req;
  assign bus.we     = h_q.we;
  assign bus.addr   = h_q.baddr;
  assign bus.wdata  = h_q.bwdata;
endmodule

// [testbench/gssc_link_monitor.sv]
/*
  Link monitor: watches the register port between host and sensor ends
  and the sensor's calibration outputs.
  Assumes both ends share ref_clk and srst.
*/
`timescale 1ns/1ps
module gssc_link_monitor (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Register port
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata,
  // Sensor outputs
  input wire logic        zero_pulse,
  input wire logic [15:0] gain_value
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire gain_wr = ack && we && (addr == gssc_pkg::REG_GAIN);
  wire hlth_rd = ack && !we && (addr == gssc_pkg::REG_HEALTH);
  wire gain_ok = (wdata >= gssc_pkg::GAIN_MIN) && (wdata <= gssc_pkg::GAIN_MAX);
  property p_gain_clamp;
    gain_wr && !gain_ok |-> ##[0:2] gain_value == gssc_pkg::GAIN_DEFAULT;
  endproperty
  a_gain_clamp: assert property (p_gain_clamp)
    else $error("gain outside range not replaced by default");
  property p_gain_keep;
    gain_wr && gain_ok |-> gain_value == wdata;
  endproperty
  a_gain_keep: assert property (p_gain_keep)
    else $error("gain inside range not stored");
  property p_zero_delay;
    ack && we && addr == gssc_pkg::REG_ZERO_REF && wdata == gssc_pkg::ZERO_CMD
      |-> ##[13:18] zero_pulse;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("zero pulse missing after zero command");
  property p_zero_once;
    zero_pulse |=> !zero_pulse;
  endproperty
  a_zero_once: assert property (p_zero_once)
    else $error("zero pulse longer than one cycle");
  property p_reserved;
    hlth_rd |-> (rdata & 16'h0719) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved health bit set");
  property p_fixed_flags;
    hlth_rd |-> rdata[6] && rdata[14];
  endproperty
  a_fixed_flags: assert property (p_fixed_flags)
    else $error("compensation or power flag clear");
  property p_unit;
    ack && !we && addr == gssc_pkg::REG_UNIT |-> rdata == gssc_pkg::UNIT_DEFAULT;
  endproperty
  a_unit: assert property (p_unit)
    else $error("unit code wrong");
  property p_ack_prompt;
    $rose(req) |=> ack;
  endproperty
  a_ack_prompt: assert property (p_ack_prompt)
    else $error("request not answered next cycle");
endmodule

// [testbench/tb_gas_sensor_status_calibration.sv]
/*
  Testbench: AHB-Lite master on the host end, sensor inputs driven
  directly, link monitor beside the joining interface.
  Assumes shortened boot and warm-up counts of 200 and 50 cycles.
*/
`timescale 1ns/1ps
module tb_gas_sensor_status_calibration;
  typedef struct packed {
    logic [2:0]  cmd;
    logic [15:0] addr;
    logic [15:0] data;
    logic [15:0] exp;
  } gssc_row_t;
  localparam int ROWS = 13;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] raw_reading = 16'h03D2;
  logic [15:0] full_scale = 16'h03E8;
  logic        sys_fault = 1'b0;
  logic        nvm_fault = 1'b0;
  logic        watchdog_event = 1'b0;
  logic        drift_averaging = 1'b0;
  logic        zero_pulse;
  logic [15:0] gain_value;
  int          bad_count = 0;
  int          n_compared = 0;
  gssc_row_t   rows [ROWS];
  logic [15:0] lim [4];
  logic [15:0] v;
  logic [31:0] w;

  always #4 ref_clk = ~ref_clk;

  gssc_if bus_if ();
  gssc_host u_gssc_host (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'h2),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .bus       (bus_if.host)
  );
  gssc_sensor #(.BOOT_CYCLES(200), .WARMUP_CYCLES(50)) u_gssc_sensor (
    .ref_clk         (ref_clk),
    .srst            (srst),
    .bus             (bus_if.dev),
    .raw_reading     (raw_reading),
    .full_scale      (full_scale),
    .sys_fault       (sys_fault),
    .nvm_fault       (nvm_fault),
    .watchdog_event  (watchdog_event),
    .drift_averaging (drift_averaging),
    .zero_pulse      (zero_pulse),
    .gain_value      (gain_value)
  );
  gssc_link_monitor u_gssc_link_monitor (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .req        (bus_if.req),
    .we         (bus_if.we),
    .addr       (bus_if.addr),
    .wdata      (bus_if.wdata),
    .ack        (bus_if.ack),
    .rdata      (bus_if.rdata),
    .zero_pulse (zero_pulse),
    .gain_value (gain_value)
  );

  task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    r = hrdata;
  endtask

  // Command through host registers, wait for done, fetch read data
  task automatic run(input logic [2:0] c, input logic [15:0] a, input logic [15:0] d,
                     output logic [15:0] r);
    logic [31:0] s;
    ahb(1'b1, 8'h04, {16'h0, a}, s);
    ahb(1'b1, 8'h08, {16'h0, d}, s);
    ahb(1'b1, 8'h00, {29'h0, c}, s);
    s = 32'h0;
    for (int i = 0; i < 100 && s[1] !== 1'b1; i++) ahb(1'b0, 8'h10, 32'h0, s);
    chk16("done", 16'h0001, {15'h0, s[1]});
    ahb(1'b1, 8'h10, 32'h2, s);
    ahb(1'b0, 8'h0C, 32'h0, s);
    r = s[15:0];
  endtask

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    $display("unexpected run length: expected under %0d cycles, seen more", 20000);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    rows[0]  = '{3'h1, 16'h004F, 16'h0000, 16'h0003};
    rows[1]  = '{3'h1, 16'h0059, 16'h0000, 16'h0000};
    rows[2]  = '{3'h1, 16'h005A, 16'h0000, 16'h2710};
    rows[3]  = '{3'h1, 16'h000A, 16'h0000, 16'h03D2};
    rows[4]  = '{3'h1, 16'h0009, 16'h0000, 16'h4040};
    rows[5]  = '{3'h2, 16'h0054, 16'h1387, 16'h2710};
    rows[6]  = '{3'h2, 16'h0054, 16'h1388, 16'h1388};
    rows[7]  = '{3'h2, 16'h0054, 16'h3A98, 16'h3A98};
    rows[8]  = '{3'h2, 16'h0054, 16'h3A99, 16'h2710};
    rows[9]  = '{3'h2, 16'h0054, 16'h2701, 16'h2701};
    rows[10] = '{3'h1, 16'h0054, 16'h0000, 16'h2701};
    rows[11] = '{3'h4, 16'h0054, 16'h03EB, 16'h2800};
    rows[12] = '{3'h5, 16'h0000, 16'h0000, 16'h2710};
    lim = '{16'h044C, 16'h044D, 16'hFF9C, 16'hFF9B};
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    run(3'h1, 16'h0009, 16'h0000, v);
    chk16("boot flags", 16'h0020, v & 16'h0022);
    run(3'h1, 16'h000A, 16'h0000, v);
    chk16("boot reading", 16'h0000, v);
    repeat (120) @(posedge ref_clk);
    run(3'h1, 16'h0009, 16'h0000, v);
    chk16("warmup flags", 16'h0022, v & 16'h0022);
    repeat (60) @(posedge ref_clk);
    for (int i = 0; i < ROWS; i++)
    begin
      run(rows[i].cmd, rows[i].addr, rows[i].data, v);
      chk16("row", rows[i].exp, (rows[i].cmd == 3'h1) ? v : gain_value);
    end
    sys_fault <= 1'b1;
    nvm_fault <= 1'b1;
    watchdog_event <= 1'b1;
    drift_averaging <= 1'b1;
    repeat (4) @(posedge ref_clk);
    run(3'h1, 16'h0009, 16'h0000, v);
    chk16("fault flags", 16'h7844, v);
    sys_fault <= 1'b0;
    nvm_fault <= 1'b0;
    watchdog_event <= 1'b0;
    drift_averaging <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 2; i++)
    begin
      run(3'h1, 16'h0009, 16'h0000, v);
      chk16("flags after clear", 16'h6040, v);
    end
    for (int i = 0; i < 4; i++)
    begin
      raw_reading <= lim[i];
      repeat (2) @(posedge ref_clk);
      run(3'h1, 16'h0009, 16'h0000, v);
      chk16("limit flag", {15'h0, i[0]}, {15'h0, v[15]});
    end
    run(3'h3, 16'h0047, 16'h0001, v);
    repeat (20) @(posedge ref_clk);
    run(3'h1, 16'h0009, 16'h0000, v);
    chk16("zero set flag", 16'h0080, v & 16'h0080);
    run(3'h5, 16'h0000, 16'h0000, v);
    run(3'h1, 16'h0047, 16'h0000, v);
    chk16("factory zero", 16'h0000, v);
    run(3'h2, 16'h0054, 16'h3000, v);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    chk16("gain after reset", 16'h2710, gain_value);
    run(3'h1, 16'h0009, 16'h0000, v);
    chk16("flags after reset", 16'h4060, v);
    ahb(1'b0, 8'h14, 32'h0, w);
    chk16("hresp", 16'h0000, {15'h0, hresp});
    print_verdict();
  end
endmodule
